//--- core/txn_region_abort_control.sv
// Region nesting, commit and abort control with an AXI4-Lite register file
//
// Contract
// - Count up on each region begin, down on each region end.
// - Commit only when outermost region end brings the count to zero.
// - Abort when nesting would exceed the maximum depth.
// - Restricted instructions inside elision abort and re-execute without elision.
// - Status bit 0 set exactly for an explicit abort.
// - Bit 1 flags possible retry success, forced clear when bit 0 set.
// - Bit 2 flags a conflict by another logical processor.
// - Bit 3 flags a tracking buffer overflow.
// - Bit 4 flags a debug or breakpoint exception.
// - Bit 5 flags an abort while nested.
// - Bits 23:6 reserved zero; 31:24 carry explicit argument only then.
// - Status reports causes only and may be zero after an abort.
// - Commit is atomic and carries locked-instruction ordering, even empty.
// - Begin does no fencing; abort discards all region memory updates.
// - Default debug abort restores state, redirects to fallback, sets bit 4.
// - With both debug enables, roll back before begin and deliver debug exception.
// - Advanced debug mode clears debug-status bit 16.
// - Architectural state updates only on commit.
// - Explicit abort, identification and spin hint always abort.
// - Transactional instructions accepted at every privilege level.
// - Ordinary register and flag operations do not abort; here a direction flag set or clear that changes the flag aborts.
// - Abort resumes at fallback with begin state, status updated.
// - Explicit abort immediate lands in status bits 31:24.
`timescale 1ns/100ps
module txn_region_abort_control #(
    parameter int MAX_NEST_DEPTH = txn_pkg::DEPTH_DEFAULT,
    parameter int CNT_W          = 4
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire txn_pkg::instr_ev_t        instr_ev,
    input  wire txn_pkg::cause_ev_t        cause_ev,
    input  wire logic                      string_direction_flag,
    output txn_pkg::action_t               action,
    output logic                           in_txn,
    input  wire logic [txn_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [txn_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);
    import txn_pkg::*;

    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
    localparam logic [CNT_W-1:0] CNT_MAX  = CNT_W'(MAX_NEST_DEPTH);

    txn_state_t       state_ff,   nxt_state;
    logic [CNT_W-1:0] nest_ff,    nxt_nest;
    logic [31:0]      status_ff,  nxt_status;
    logic [31:0]      saved_ff;
    logic [31:0]      dbgstat_ff;
    logic [1:0]       ctrl_ff;
    action_t          action_ff,  nxt_action;

    // Event decode; privilege level is never consulted, so no fault path exists
    // Ordinary register and vector operations have no input here and cannot abort; a direction flag set or clear aborts only when it changes the flag
    wire        active      = (state_ff == S_TXN);
    wire        begin_ev    = instr_ev.region_begin_instr;
    wire        end_ev      = instr_ev.region_end_instr & active;
    wire        dir_change  = (instr_ev.clear_direction_instr & string_direction_flag) |
                              (instr_ev.set_direction_instr & ~string_direction_flag);
    wire        ab_explicit = active & instr_ev.explicit_abort_instr;
    wire        ab_instr    = active & (instr_ev.identification_instr | instr_ev.spin_hint_instr |
                              dir_change);
    wire        ab_depth    = begin_ev & (nest_ff == CNT_MAX);
    wire        ab_dbg      = active & (cause_ev.debug_exception | cause_ev.breakpoint_exception);
    wire        ab_conf     = active & cause_ev.conflict;
    wire        ab_ovf      = active & (cause_ev.buf_overflow | ab_depth);
    wire        ab_elide    = begin_ev & instr_ev.lock_elision_active;
    wire        ab_other    = active & cause_ev.other_abort;
    wire        any_abort   = ab_explicit | ab_instr | ab_dbg | ab_conf | ab_ovf | ab_other | ab_elide;
    wire        adv_debug   = ctrl_ff[CTL_DBGCTL_B11] & ctrl_ff[CTL_MSR_B15];
    wire        outer_end   = end_ev & (nest_ff == CNT_ONE) & ~any_abort;

    // Abort cause word; reserved bits stay zero and an abort with no cause outside a nested region gives zero
    logic [31:0] cause_word;
    always_comb begin
        cause_word = ZERO32;
        cause_word[ST_EXPLICIT] = ab_explicit;
        cause_word[ST_RETRY]    = ~ab_explicit & (ab_conf | ab_other);
        cause_word[ST_CONFLICT] = ab_conf;
        cause_word[ST_OVERFLOW] = ab_ovf;
        cause_word[ST_DEBUG]    = ab_dbg;
        cause_word[ST_NESTED]   = (nest_ff > CNT_ONE);
        if (ab_explicit) begin
            cause_word[ST_ARG_LSB +: ARG_W] = instr_ev.abort_arg;
        end
    end

    // Nesting and commit/abort sequencing
    always_comb begin
        nxt_state  = state_ff;
        nxt_nest   = nest_ff;
        nxt_status = status_ff;
        nxt_action = '0;
        case (state_ff)
            S_IDLE: begin
                if (ab_elide) begin
                    nxt_action.elision_reexec = 1'b1;
                end else if (begin_ev) begin
                    // Begin imposes no fence; it only opens the region
                    nxt_state = S_TXN;
                    nxt_nest  = CNT_ONE;
                end
            end
            S_TXN: begin
                if (any_abort) begin
                    nxt_state               = S_IDLE;
                    nxt_nest                = CNT_ZERO;
                    nxt_action.abort        = 1'b1;
                    nxt_action.discard_spec = 1'b1;
                    nxt_action.restore_arch = 1'b1;
                    nxt_action.elision_reexec = ab_elide;
                    if (ab_dbg & adv_debug) begin
                        nxt_action.rollback_before_begin   = 1'b1;
                        nxt_action.deliver_debug_exception = 1'b1;
                        nxt_status                         = saved_ff;
                    end else begin
                        nxt_action.redirect_fallback = 1'b1;
                        nxt_status                   = cause_word;
                    end
                end else if (outer_end) begin
                    nxt_state               = S_IDLE;
                    nxt_nest                = CNT_ZERO;
                    nxt_action.commit       = 1'b1;
                    nxt_action.locked_order = 1'b1;
                end else if (begin_ev) begin
                    nxt_nest = nest_ff + CNT_ONE;
                end else if (end_ev) begin
                    nxt_nest = nest_ff - CNT_ONE;
                end
            end
            default: begin
                nxt_state = S_IDLE;
                nxt_nest  = CNT_ZERO;
            end
        endcase
    end

    // AXI4-Lite slave: one write and one read in flight, address and data in either order
    logic        aw_ok_ff, w_ok_ff, bvalid_ff, rvalid_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0]  wstrb_ff;
    logic [1:0]  bresp_ff, rresp_ff;

    assign s_axi_awready = ~aw_ok_ff & ~bvalid_ff;
    assign s_axi_wready  = ~w_ok_ff & ~bvalid_ff;
    assign s_axi_arready = ~rvalid_ff;
    wire   wr_fire  = aw_ok_ff & w_ok_ff & ~bvalid_ff;
    wire   rd_fire  = s_axi_arvalid & s_axi_arready;
    wire   wr_stat  = wr_fire & (awaddr_ff == OFF_STATUS);
    wire   wr_ctrl  = wr_fire & (awaddr_ff == OFF_CTRL);
    wire   wr_map   = wr_stat | wr_ctrl;
    wire   rd_map   = (s_axi_araddr == OFF_STATUS) | (s_axi_araddr == OFF_CTRL) |
                      (s_axi_araddr == OFF_STATE) | (s_axi_araddr == OFF_DBGSTAT);
    wire [31:0] state_word = {{(32-CNT_W-1){1'b0}}, nest_ff, active};
    wire [31:0] rd_mux = (s_axi_araddr == OFF_STATUS)  ? status_ff :
                         (s_axi_araddr == OFF_CTRL)    ? {30'h0, ctrl_ff} :
                         (s_axi_araddr == OFF_STATE)   ? state_word :
                         (s_axi_araddr == OFF_DBGSTAT) ? dbgstat_ff : ZERO32;
    wire [31:0] wmask  = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    wire [31:0] st_wr  = (status_ff & ~wmask) | (wdata_ff & wmask);

    // Write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok_ff  <= 1'b0;
            w_ok_ff   <= 1'b0;
            bvalid_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff  <= ZERO32;
            wstrb_ff  <= 4'h0;
            bresp_ff  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_ok_ff  <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_ok_ff  <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_ok_ff  <= 1'b0;
                w_ok_ff   <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_ff & s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= ZERO32;
            rresp_ff  <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
            rresp_ff  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_ff & s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Core state; a hardware abort update wins over a same-cycle software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff   <= S_IDLE;
            nest_ff    <= CNT_ZERO;
            status_ff  <= ZERO32;
            saved_ff   <= ZERO32;
            ctrl_ff    <= 2'b00;
            dbgstat_ff <= DBGSTAT_RESET;
            action_ff  <= '0;
        end else begin
            state_ff  <= nxt_state;
            nest_ff   <= nxt_nest;
            action_ff <= nxt_action;
            if (nxt_action.abort) begin
                status_ff <= nxt_status;
            end else if (wr_stat) begin
                status_ff <= st_wr;
            end
            // Snapshot the status word at outermost begin for debug rollback
            if (!active & begin_ev) begin
                saved_ff <= status_ff;
            end
            if (wr_ctrl & wstrb_ff[0]) begin
                ctrl_ff <= wdata_ff[1:0];
            end
            if (nxt_action.deliver_debug_exception) begin
                dbgstat_ff[DBG_TXN_BIT] <= 1'b0;
            end else if (wr_fire & (awaddr_ff == OFF_DBGSTAT)) begin
                dbgstat_ff[DBG_TXN_BIT] <= 1'b1;
            end
        end
    end

    assign action        = action_ff;
    assign in_txn        = active;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
endmodule

//--- core/txn_pkg.sv
// Package: register map, status word layout and enumerations for the region abort controller
package txn_pkg;
    localparam int          DATA_W          = 32;
    localparam int          ADDR_W          = 8;
    // Register byte offsets
    localparam logic [7:0]  OFF_STATUS      = 8'h00;
    localparam logic [7:0]  OFF_CTRL        = 8'h04;
    localparam logic [7:0]  OFF_STATE       = 8'h08;
    localparam logic [7:0]  OFF_DBGSTAT     = 8'h0c;
    // Status word field positions
    localparam int          ST_EXPLICIT     = 0;
    localparam int          ST_RETRY        = 1;
    localparam int          ST_CONFLICT     = 2;
    localparam int          ST_OVERFLOW     = 3;
    localparam int          ST_DEBUG        = 4;
    localparam int          ST_NESTED       = 5;
    localparam int          ST_ARG_LSB      = 24;
    localparam int          ARG_W           = 8;
    // Control register bits
    localparam int          CTL_DBGCTL_B11  = 0;
    localparam int          CTL_MSR_B15     = 1;
    localparam int          DBG_TXN_BIT     = 16;
    localparam logic [31:0] DBGSTAT_RESET   = 32'hffff0ff0;
    localparam logic [31:0] ZERO32          = 32'h00000000;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
    localparam int          DEPTH_DEFAULT   = 7;

    // Instruction retirement events presented by the core pipeline
    typedef struct packed {
        logic       region_begin_instr;
        logic       region_end_instr;
        logic       explicit_abort_instr;
        logic [7:0] abort_arg;
        logic       identification_instr;
        logic       spin_hint_instr;
        logic       clear_direction_instr;
        logic       set_direction_instr;
        logic       lock_elision_active;
    } instr_ev_t;

    // Asynchronous and memory-side abort causes
    typedef struct packed {
        logic conflict;
        logic buf_overflow;
        logic debug_exception;
        logic breakpoint_exception;
        logic other_abort;
    } cause_ev_t;

    // Actions issued toward the core
    typedef struct packed {
        logic commit;
        logic locked_order;
        logic abort;
        logic discard_spec;
        logic restore_arch;
        logic redirect_fallback;
        logic rollback_before_begin;
        logic deliver_debug_exception;
        logic elision_reexec;
    } action_t;

    typedef enum logic [1:0] {S_IDLE, S_TXN} txn_state_t;
endpackage

//--- test/txn_region_abort_control_chk.sv
// Concurrent checks on the region abort controller core-side ports
`timescale 1ns/100ps
module txn_region_abort_control_chk (
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire txn_pkg::instr_ev_t  instr_ev,
    input wire txn_pkg::cause_ev_t  cause_ev,
    input wire txn_pkg::action_t    action,
    input wire logic                in_txn
);
    import txn_pkg::*;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Instructions that end a region whatever else is going on
    wire logic forced = instr_ev.explicit_abort_instr | instr_ev.identification_instr | instr_ev.spin_hint_instr;

    property p_commit_order; action.commit |-> action.locked_order && !action.abort; endproperty
    a_commit_order: assert property (p_commit_order) else $error("commit without locked order");
    property p_commit_cause; action.commit |-> $past(instr_ev.region_end_instr) && $past(in_txn) && !in_txn; endproperty
    a_commit_cause: assert property (p_commit_cause) else $error("commit without outer end");
    property p_abort_discard; action.abort |-> action.discard_spec && action.restore_arch && !in_txn; endproperty
    a_abort_discard: assert property (p_abort_discard) else $error("abort kept region state");
    property p_abort_path; action.abort |-> action.redirect_fallback ^ action.rollback_before_begin; endproperty
    a_abort_path: assert property (p_abort_path) else $error("abort resume path wrong");
    property p_rollback; action.rollback_before_begin |-> action.deliver_debug_exception && action.abort; endproperty
    a_rollback: assert property (p_rollback) else $error("rollback without debug delivery");
    property p_forced; in_txn && forced |=> action.abort; endproperty
    a_forced: assert property (p_forced) else $error("forced abort missing");
    property p_enter;
        !in_txn && instr_ev.region_begin_instr && !instr_ev.lock_elision_active && !forced |=> in_txn;
    endproperty
    a_enter: assert property (p_enter) else $error("begin did not open region");
    property p_elide;
        !in_txn && instr_ev.region_begin_instr && instr_ev.lock_elision_active |=> action.elision_reexec && !in_txn;
    endproperty
    a_elide: assert property (p_elide) else $error("elided begin not re-executed");

    c_commit: cover property (action.commit);
    c_abort: cover property (action.abort);
    c_rollback: cover property (action.rollback_before_begin);
    c_elide: cover property (action.elision_reexec);
endmodule

//--- test/tb.sv
// Directed testbench for the region abort controller
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
    import txn_pkg::*;
    // Event words: begin, end, explicit, arg[7:0], ident, spin, clear dir, set dir, elision
    localparam instr_ev_t  BEG = 16'h8000, END = 16'h4000, XAB = 16'h2b40, BEG_LE = 16'h8001;
    localparam instr_ev_t  IEV [6] = '{16'h0010, 16'h0008, 16'h0002, 16'h0004, 16'h0004, 16'h0002};
    localparam logic [5:0] ABV = 6'b101011, SDFV = 6'b001100;
    localparam logic [31:0] CEXP [5] = '{32'h06, 32'h08, 32'h10, 32'h10, 32'h02};
    logic              aclk = 0, aresetn = 0, sdf = 0, in_txn;
    instr_ev_t         ie = '0;
    cause_ev_t         ce = '0;
    action_t           action, act;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0]       wdata = '0, rdata, d;
    logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp, r;
    int                bad_count = 0, cmp_count = 0;

    txn_region_abort_control txn_region_abort_control_i (.aclk(aclk), .aresetn(aresetn), .instr_ev(ie),
        .cause_ev(ce), .string_direction_flag(sdf), .action(action), .in_txn(in_txn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    initial begin
        forever #5 aclk = ~aclk;
    end

    // One-cycle event pulse; the action is captured once its edge has landed
    task automatic fire(input instr_ev_t i, input cause_ev_t c);
        @(posedge aclk);
        ie <= i;
        ce <= c;
        @(posedge aclk);
        ie <= '0;
        ce <= '0;
        #1 act = action;
    endtask

    // Write address and data offered together, each dropped once taken; only the watchdog ends the wait
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        r = bresp;
        bready <= 0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask

    task automatic t_reset;
        `CHK("in_txn after reset", 1'b0, in_txn)
        `CHK("action after reset", action_t'(0), action)
        `CHK("ready after reset", 5'b11100, {awready, wready, arready, bvalid, rvalid})
        rd(OFF_STATUS); `CHK("status", ZERO32, d)
        rd(OFF_CTRL); `CHK("ctrl", ZERO32, d)
        `CHK("ctrl rresp", RESP_OKAY, r)
        rd(OFF_DBGSTAT); `CHK("dbgstat", DBGSTAT_RESET, d)
        rd(8'h10); `CHK("unmapped rresp", RESP_SLVERR, r)
        wr(8'h10, 32'h1); `CHK("unmapped bresp", RESP_SLVERR, r)
        wr(OFF_STATE, 32'h1); `CHK("state bresp", RESP_SLVERR, r)
        $display("t_reset finished");
    endtask

    task automatic t_nest;
        fire(BEG, '0);
        fire(BEG, '0);
        rd(OFF_STATE); `CHK("state", 32'h5, d)
        fire(END, '0); `CHK("inner commit", 1'b0, act.commit)
        fire(END, '0); `CHK("commit", 2'b11, {act.commit, act.locked_order})
        `CHK("in_txn", 1'b0, in_txn)
        fire(END, '0); `CHK("stray end", 1'b0, act.commit)
        $display("t_nest finished");
    endtask

    task automatic t_explicit_abort_instr;
        fire(BEG, '0);
        fire(BEG, '0);
        fire(XAB, '0);
        `CHK("abort", 4'hf, {act.abort, act.discard_spec, act.restore_arch, act.redirect_fallback})
        rd(OFF_STATUS); `CHK("nested status", 32'h5a000021, d)
        rd(OFF_STATE); `CHK("state", ZERO32, d)
        fire(BEG, '0);
        fire(XAB, '0);
        rd(OFF_STATUS); `CHK("outer status", 32'h5a000001, d)
        // Explicit abort with a same-cycle conflict must still keep the retry bit clear
        fire(BEG, '0);
        fire(XAB, 5'h10);
        rd(OFF_STATUS); `CHK("explicit with conflict", 32'h5a000005, d)
        $display("t_explicit_abort_instr finished");
    endtask

    task automatic t_ovf;
        repeat (DEPTH_DEFAULT) fire(BEG, '0);
        rd(OFF_STATE); `CHK("full depth", 32'hf, d)
        fire(BEG, '0); `CHK("overflow abort", 1'b1, act.abort)
        rd(OFF_STATUS); `CHK("overflow status", 32'h28, d)
        $display("t_ovf finished");
    endtask

    task automatic t_cause;
        fire('0, 5'h10); `CHK("idle cause", 1'b0, act.abort)
        for (int k = 0; k < 5; k++) begin
            fire(BEG, '0);
            fire('0, cause_ev_t'(5'h10 >> k)); `CHK("fallback", 1'b1, act.redirect_fallback)
            rd(OFF_STATUS); `CHK("cause status", CEXP[k], d)
        end
        $display("t_cause finished");
    endtask

    task automatic t_instr;
        for (int k = 0; k < 6; k++) begin
            wr(OFF_STATUS, 32'hff);
            @(posedge aclk);
            sdf <= SDFV[k];
            fire(BEG, '0);
            fire(IEV[k], '0); `CHK("instr abort", ABV[k], act.abort)
            if (ABV[k]) begin
                rd(OFF_STATUS); `CHK("zero status", ZERO32, d)
            end else begin
                fire(END, '0); `CHK("no abort commit", 1'b1, act.commit)
            end
        end
        $display("t_instr finished");
    endtask

    task automatic t_adv;
        wr(OFF_CTRL, 32'h3); `CHK("ctrl bresp", RESP_OKAY, r)
        rd(OFF_CTRL); `CHK("ctrl", 32'h3, d)
        wr(OFF_STATUS, 32'h2a);
        fire(BEG, '0);
        fire('0, 5'h02);
        `CHK("rollback", 3'b110, {act.rollback_before_begin, act.deliver_debug_exception, act.redirect_fallback})
        rd(OFF_STATUS); `CHK("restored status", 32'h2a, d)
        rd(OFF_DBGSTAT); `CHK("dbgstat", 32'hfffe0ff0, d)
        // Any write to the debug status re-arms the in-region bit but is refused on the bus
        wr(OFF_DBGSTAT, ZERO32); `CHK("dbgstat bresp", RESP_SLVERR, r)
        rd(OFF_DBGSTAT); `CHK("dbgstat rearmed", DBGSTAT_RESET, d)
        wr(OFF_CTRL, 32'h1);
        fire(BEG, '0);
        fire('0, 5'h04); `CHK("one enable", 2'b01, {act.rollback_before_begin, act.redirect_fallback})
        wr(OFF_CTRL, 32'h0);
        $display("t_adv finished");
    endtask

    task automatic t_elide;
        fire(BEG_LE, '0); `CHK("reexec", 1'b1, act.elision_reexec)
        `CHK("no region", 1'b0, in_txn)
        $display("t_elide finished");
    endtask

    // Mid-run reset drops an open region and clears the status word
    task automatic t_rst;
        wr(OFF_STATUS, 32'h3c);
        fire(BEG, '0);
        @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        `CHK("in_txn after mid reset", 1'b0, in_txn)
        rd(OFF_STATUS); `CHK("status after mid reset", ZERO32, d)
        rd(OFF_STATE); `CHK("state after mid reset", ZERO32, d)
        $display("t_rst finished");
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        t_reset;
        t_nest;
        t_explicit_abort_instr;
        t_ovf;
        t_cause;
        t_instr;
        t_adv;
        t_elide;
        t_rst;
        test_done;
    end

    // The whole run needs a few hundred cycles; this cuts a hang short
    initial begin
        #100000;
        bad_count++;
        test_done;
    end
endmodule

bind txn_region_abort_control txn_region_abort_control_chk txn_region_abort_control_chk_i (.aclk(aclk),
    .aresetn(aresetn), .instr_ev(instr_ev), .cause_ev(cause_ev), .action(action), .in_txn(in_txn));
